/* File: core/ofd_core.v */
// Purpose: operand field decode, fault priority check, bus lock and flag load filter
// Assumes: single clock hclk, AHB-Lite slave with zero wait states, OKAY always
// Notes: a write to the check register launches one evaluation in the next cycle
`timescale 1ns/1ns
`include "ofd_defs.vh"
module ofd_core
(
  // bus clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // fault, lock and extra clock outputs
  output reg fault_stb,
  output reg [7:0] fault_num,
  output reg bus_lock,
  output reg extra_clock
);

  // control: bit0 protected mode, bits2:1 current privilege level
  reg [2:0] ctrl_q;
  // instruction descriptor, see field comments below
  reg [15:0] insn_q;
  // check conditions supplied by execution logic
  reg [15:0] chk_q;
  // flag word: raw value written, filtered value held
  reg [15:0] flags_q;
  reg [15:0] oper_q;
  reg [15:0] imm_raw_q;
  reg go_q;
  reg zero_flag_q;
  reg no_result_q;
  reg [7:0] last_num_q;
  reg [2:0] xfer_q;
  // ahb address phase capture
  reg wr_pend_q;
  reg rd_pend_q;
  reg [4:0] addr_q;

  wire prot = ctrl_q[`OFD_CTL_PROT];
  wire [1:0] current_privilege_level = ctrl_q[`OFD_CTL_PL_HI:`OFD_CTL_PL_LO];
  wire [1:0] io_privilege_level = flags_q[`OFD_FLG_IOPRIV_HI:`OFD_FLG_IOPRIV_LO];
  // insn fields
  wire dir_bit = insn_q[`OFD_INS_DIR];
  wire size_bit = insn_q[`OFD_INS_SIZE];
  wire narrow_bit = insn_q[`OFD_INS_NARROW];
  wire is_prot_only = insn_q[`OFD_INS_PROT_ONLY];
  wire is_auto_lock = insn_q[`OFD_INS_AUTO_LOCK];
  wire is_multi_xfer = insn_q[`OFD_INS_MULTI];
  wire is_desc_access = insn_q[`OFD_INS_DESC];
  wire is_far_xfer = insn_q[`OFD_INS_FAR];
  wire is_level0 = insn_q[`OFD_INS_LEVEL0];
  wire is_io_sens = insn_q[`OFD_INS_IO_SENS];
  wire is_seg_load = insn_q[`OFD_INS_SEG_LOAD];
  wire is_ss_dest = insn_q[`OFD_INS_SS_DEST];
  wire is_sel_check = insn_q[`OFD_INS_SEL_CHECK];
  wire is_coproc_opcode_group = insn_q[`OFD_INS_COPROC];
  wire three_elem = insn_q[`OFD_INS_THREE];
  wire mem_op = insn_q[`OFD_INS_MEM];
  // chk fields and operand offset: raw conditions
  wire [15:0] offset = oper_q;
  wire lim_viol = chk_q[`OFD_CHK_LIM];
  wire acc_viol = chk_q[`OFD_CHK_ACC];
  wire stk_lim_viol = chk_q[`OFD_CHK_STK];
  wire not_present = chk_q[`OFD_CHK_NP];
  wire [1:0] requested_privilege_level = chk_q[`OFD_CHK_REQPL_HI:`OFD_CHK_REQPL_LO];
  wire [1:0] descriptor_privilege_level = chk_q[`OFD_CHK_DESCPL_HI:`OFD_CHK_DESCPL_LO];
  wire xfer_priv_viol = chk_q[`OFD_CHK_XPRIV];
  wire target_out_code = chk_q[`OFD_CHK_TARGET];
  wire cop_xfer_overrun = chk_q[`OFD_CHK_XOVR];

  // privilege agreement for a data segment load
  function priv_ok;
    input [1:0] cur_pl;
    input [1:0] req_pl;
    input [1:0] desc_pl;
    begin
      priv_ok = (desc_pl >= cur_pl) && (desc_pl >= req_pl);
    end
  endfunction

  wire seg_priv_bad = !priv_ok(current_privilege_level, requested_privilege_level, descriptor_privilege_level);
  wire cpl_above_io = current_privilege_level > io_privilege_level;

  // checks listed in instruction order, first hit wins
  reg hit;
  reg [7:0] num;
  always @*
  begin
    hit = 1'b0;
    num = 8'h00;
    if (!prot)
    begin
      if (is_prot_only)
      begin
        hit = 1'b1;
        num = `OFD_EXC_UNDEF;
      end
      else if (mem_op && size_bit && offset == `OFD_OFS_LAST)
      begin
        hit = 1'b1;
        num = `OFD_EXC_GP;
      end
      else if (is_coproc_opcode_group && lim_viol)
      begin
        hit = 1'b1;
        num = `OFD_EXC_CSO;
      end
    end
    else if (is_level0 && current_privilege_level != `OFD_ZERO_PL)
    begin
      hit = 1'b1;
      num = `OFD_EXC_GP;
    end
    else if (is_io_sens && cpl_above_io)
    begin
      hit = 1'b1;
      num = `OFD_EXC_GP;
    end
    else if (is_far_xfer && (xfer_priv_viol || target_out_code))
    begin
      hit = 1'b1;
      num = `OFD_EXC_GP;
    end
    else if (is_seg_load && !is_sel_check && seg_priv_bad)
    begin
      hit = 1'b1;
      num = `OFD_EXC_GP;
    end
    else if (is_seg_load && !is_sel_check && not_present)
    begin
      hit = 1'b1;
      num = is_ss_dest ? `OFD_EXC_SS : `OFD_EXC_NP;
    end
    else if ((mem_op || is_coproc_opcode_group) && (lim_viol || acc_viol))
    begin
      hit = 1'b1;
      num = `OFD_EXC_GP;
    end
    else if ((mem_op || is_coproc_opcode_group) && stk_lim_viol)
    begin
      hit = 1'b1;
      num = `OFD_EXC_SS;
    end
    else if (is_coproc_opcode_group && cop_xfer_overrun)
    begin
      hit = 1'b1;
      num = `OFD_EXC_CSO;
    end
  end

  // selector check failure is silent: no result and zero flag cleared
  wire sel_fail = prot && is_sel_check && (seg_priv_bad || not_present);

  // immediate operand shaping
  wire [15:0] imm_val = narrow_bit ? {{8{imm_raw_q[7]}}, imm_raw_q[7:0]} : imm_raw_q;
  wire [15:0] imm_sized = size_bit ? imm_val : {8'h00, imm_val[7:0]};

  // flag word filter on load
  function [15:0] flag_filter;
    input [15:0] old_f;
    input [15:0] new_f;
    input p;
    input [1:0] cur_pl;
    input above;
    reg [15:0] f;
    begin
      f = new_f;
      if (!p)
      begin
        f[`OFD_FLG_IOPRIV_HI:`OFD_FLG_IOPRIV_LO] = 2'h0;
        f[`OFD_FLG_NEST] = 1'b0;
      end
      else
      begin
        if (above)
          f[`OFD_FLG_IF] = old_f[`OFD_FLG_IF];
        if (cur_pl != `OFD_ZERO_PL)
          f[`OFD_FLG_IOPRIV_HI:`OFD_FLG_IOPRIV_LO] = old_f[`OFD_FLG_IOPRIV_HI:`OFD_FLG_IOPRIV_LO];
      end
      flag_filter = f;
    end
  endfunction

  // one-hot register select from a word offset; shared by the write and read paths
  function [6:0] reg_sel;
    input [4:0] a;
    begin
      case ({27'h000_0000, a})
        `OFD_REG_CTRL: reg_sel = 7'h01;
        `OFD_REG_INSN: reg_sel = 7'h02;
        `OFD_REG_CHK: reg_sel = 7'h04;
        `OFD_REG_FLAGS: reg_sel = 7'h08;
        `OFD_REG_STAT: reg_sel = 7'h10;
        `OFD_REG_OPER: reg_sel = 7'h20;
        `OFD_REG_IMM: reg_sel = 7'h40;
        default: reg_sel = 7'h00;
      endcase
    end
  endfunction

  wire bus_wr = wr_pend_q;
  wire take = hsel && hready && htrans[1];
  wire [6:0] wr_sel = reg_sel(addr_q);
  wire [6:0] rd_sel = reg_sel(haddr[4:0]);
  // a faulting instruction never locks, so it must not start the multi-transfer toggling either
  wire lock_want = (is_auto_lock || (prot && is_desc_access)) && !hit;

  // read word of each register, in select order
  wire [31:0] rd_word [0:6];
  assign rd_word[0] = {29'h0000_0000, ctrl_q};
  assign rd_word[1] = {16'h0000, insn_q};
  assign rd_word[2] = {16'h0000, chk_q};
  assign rd_word[3] = {16'h0000, flags_q};
  assign rd_word[4] = {19'h0_0000, bus_lock, zero_flag_q, no_result_q, dir_bit, size_bit, last_num_q};
  assign rd_word[5] = {16'h0000, oper_q};
  assign rd_word[6] = {16'h0000, imm_sized};

  // and-or fold over the one-hot select; unmapped offsets leave it at zero
  wire [31:0] rd_fold [0:7];
  assign rd_fold[0] = 32'h0000_0000;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_rd_fold
      assign rd_fold[gi + 1] = rd_fold[gi] | (rd_word[gi] & {32{rd_sel[gi]}});
    end
  endgenerate

  // address phase capture; the slave never stretches a transfer
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 5'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take)
        addr_q <= haddr[4:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // writes land in the data phase; a check write also launches one evaluation
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= 3'h0;
      insn_q <= 16'h0000;
      chk_q <= 16'h0000;
      flags_q <= 16'h0000;
      oper_q <= 16'h0000;
      imm_raw_q <= 16'h0000;
      go_q <= 1'b0;
    end
    else
    begin
      go_q <= bus_wr && wr_sel[2];
      if (bus_wr && wr_sel[0])
        ctrl_q <= hwdata[2:0];
      if (bus_wr && wr_sel[1])
        insn_q <= hwdata[15:0];
      if (bus_wr && wr_sel[2])
        chk_q <= hwdata[15:0];
      if (bus_wr && wr_sel[3])
        flags_q <= flag_filter(flags_q, hwdata[15:0], prot, current_privilege_level, cpl_above_io);
      if (bus_wr && wr_sel[5])
        oper_q <= hwdata[15:0];
      if (bus_wr && wr_sel[6])
        imm_raw_q <= hwdata[15:0];
    end
  end

  // one evaluation per launch; strobe lasts one cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fault_stb <= 1'b0;
      fault_num <= 8'h00;
      last_num_q <= 8'h00;
      extra_clock <= 1'b0;
      zero_flag_q <= 1'b0;
      no_result_q <= 1'b0;
    end
    else
    begin
      fault_stb <= go_q && hit;
      if (go_q && hit)
      begin
        fault_num <= num;
        last_num_q <= num;
      end
      if (go_q)
      begin
        extra_clock <= three_elem;
        no_result_q <= sel_fail;
        if (sel_fail)
          zero_flag_q <= 1'b0;
        else if (is_sel_check)
          zero_flag_q <= 1'b1;
      end
    end
  end

  // lock held for one cycle per transfer; multi-transfer drops it between transfers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_lock <= 1'b0;
      xfer_q <= 3'h0;
    end
    else if (go_q)
    begin
      xfer_q <= (is_multi_xfer && lock_want) ? `OFD_XFER_STEPS : 3'h0;
      bus_lock <= lock_want;
    end
    else if (xfer_q != 3'h0)
    begin
      xfer_q <= xfer_q - 3'h1;
      bus_lock <= ~bus_lock;
    end
    else
      bus_lock <= 1'b0;
  end

  // read data is registered at the address phase and stands for the data phase only
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= rd_fold[7];
    else if (rd_pend_q)
      hrdata <= 32'h0000_0000;
  end

endmodule

/* File: core/ofd_defs.vh */
// Purpose: constants for the operand field decode and fault check block
// Assumes: included by core/ofd_core.v
// Notes: exception numbers are 8 bits wide
`ifndef OFD_DEFS_VH
`define OFD_DEFS_VH
`define OFD_EXC_UNDEF 8'h06
`define OFD_EXC_CSO 8'h09
`define OFD_EXC_NP 8'h0B
`define OFD_EXC_SS 8'h0C
`define OFD_EXC_GP 8'h0D
`define OFD_OFS_LAST 16'hFFFF
`define OFD_ZERO_PL 2'h0
// flag word field positions
`define OFD_FLG_IF 9
`define OFD_FLG_IOPRIV_LO 12
`define OFD_FLG_IOPRIV_HI 13
`define OFD_FLG_NEST 14
// control word fields
`define OFD_CTL_PROT 0
`define OFD_CTL_PL_LO 1
`define OFD_CTL_PL_HI 2
// instruction descriptor fields
`define OFD_INS_DIR 0
`define OFD_INS_SIZE 1
`define OFD_INS_NARROW 2
`define OFD_INS_PROT_ONLY 3
`define OFD_INS_AUTO_LOCK 4
`define OFD_INS_MULTI 5
`define OFD_INS_DESC 6
`define OFD_INS_FAR 7
`define OFD_INS_LEVEL0 8
`define OFD_INS_IO_SENS 9
`define OFD_INS_SEG_LOAD 10
`define OFD_INS_SS_DEST 11
`define OFD_INS_SEL_CHECK 12
`define OFD_INS_COPROC 13
`define OFD_INS_THREE 14
`define OFD_INS_MEM 15
// check word fields
`define OFD_CHK_LIM 0
`define OFD_CHK_ACC 1
`define OFD_CHK_STK 2
`define OFD_CHK_NP 3
`define OFD_CHK_REQPL_LO 4
`define OFD_CHK_REQPL_HI 5
`define OFD_CHK_DESCPL_LO 6
`define OFD_CHK_DESCPL_HI 7
`define OFD_CHK_XPRIV 8
`define OFD_CHK_TARGET 9
`define OFD_CHK_XOVR 10
// lock sequence length after a multi-transfer launch
`define OFD_XFER_STEPS 3'h3
// register map
`define OFD_REG_CTRL 32'h0000_0000
`define OFD_REG_INSN 32'h0000_0004
`define OFD_REG_CHK 32'h0000_0008
`define OFD_REG_FLAGS 32'h0000_000C
`define OFD_REG_STAT 32'h0000_0010
`define OFD_REG_OPER 32'h0000_0014
`define OFD_REG_IMM 32'h0000_0018
`endif

/* File: test/ofd_core_properties.sv */
// Purpose: port assertions for ofd_core
// Assumes: one clock hclk, hresetn async low
// Notes: a check launches from the data phase of a check write
`timescale 1ns/1ns
`include "ofd_defs.vh"
module ofd_core_checker
(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // results
  input wire fault_stb,
  input wire [7:0] fault_num,
  input wire bus_lock,
  input wire extra_clock
);
  wire chk_wr = hsel && hready && htrans[1] && hwrite && (haddr == `OFD_REG_CHK);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_stb_one_cycle: assert property (fault_stb |=> !fault_stb)
    else $error("fault strobe too long");
  a_num_held: assert property ($changed(fault_num) |-> fault_stb)
    else $error("fault number moved without strobe");
  a_num_legal: assert property (fault_stb |-> fault_num inside {`OFD_EXC_UNDEF, `OFD_EXC_CSO,
    `OFD_EXC_NP, `OFD_EXC_SS, `OFD_EXC_GP}) else $error("bad fault number");
  a_stb_cause: assert property (fault_stb |-> $past(chk_wr, 3))
    else $error("strobe without check");
  a_lock_no_fault: assert property (fault_stb |-> !bus_lock)
    else $error("lock with fault");
  a_lock_pulse: assert property ($rose(bus_lock) |=> !bus_lock)
    else $error("lock not dropped");
  a_xclk_cause: assert property ($changed(extra_clock) |-> $past(chk_wr, 3))
    else $error("extra clock moved without check");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule
bind ofd_core ofd_core_checker i_ofd_core_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .fault_stb(fault_stb), .fault_num(fault_num), .bus_lock(bus_lock), .extra_clock(extra_clock));

/* File: test/ofd_seq_model.sv */
// Purpose: exception sequencer stand-in taking fault strobes
// Assumes: one clock hclk
// Notes: a stuck strobe overcounts, so the count also checks pulse width
`timescale 1ns/1ns
module ofd_seq_model
(
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // from the checker block
  input wire fault_stb,
  input wire [7:0] fault_num,
  // what was taken
  output reg [15:0] seen_cnt,
  output reg [7:0] seen_num
);
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      seen_cnt <= 16'h0000;
      seen_num <= 8'h00;
    end
    else if (fault_stb)
    begin
      seen_cnt <= seen_cnt + 16'h0001;
      seen_num <= fault_num;
    end
endmodule

/* File: test/tb_operand_field_decode_fault_check.sv */
// Purpose: directed checks of ofd_core over its register bus
// Assumes: zero wait slave, result two edges after check address phase
// Notes: no random stimulus
`timescale 1ns/1ns
`include "ofd_defs.vh"
module tb_operand_field_decode_fault_check;
  reg hclk, hresetn, hsel, hwrite;
  reg [1:0] htrans;
  reg [31:0] haddr, hwdata, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, fault_stb, bus_lock, extra_clock;
  wire [7:0] fault_num, seen_num;
  wire [15:0] seen_cnt;
  integer failures, n_tests, n_exp;
  ofd_core i_ofd_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fault_stb(fault_stb), .fault_num(fault_num),
    .bus_lock(bus_lock), .extra_clock(extra_clock));
  ofd_seq_model i_ofd_seq_model (.hclk(hclk), .hresetn(hresetn), .fault_stb(fault_stb),
    .fault_num(fault_num), .seen_cnt(seen_cnt), .seen_num(seen_num));
  initial
  begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  task print_verdict;
    begin
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task compare(input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  // ctrl, insn and check words, then strobe, number and lock one edge after the data phase
  task run(input [2:0] c, input [15:0] i, input [10:0] k, input s, input [7:0] n, input l);
    begin
      bus(1, `OFD_REG_CTRL, c);
      bus(1, `OFD_REG_INSN, i);
      bus(1, `OFD_REG_CHK, k);
      @(posedge hclk);
      @(negedge hclk);
      compare(s, fault_stb);
      compare(l, bus_lock);
      if (s)
      begin
        compare(n, fault_num);
        n_exp = n_exp + 1;
      end
    end
  endtask
  initial
  begin
    #400000;
    failures = failures + 1;
    print_verdict;
  end
  initial
  begin
    {failures, n_tests, n_exp} = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    run(0, 16'h0008, 0, 1, `OFD_EXC_UNDEF, 0);
    run(0, 16'hA008, 11'h400, 1, `OFD_EXC_UNDEF, 0);
    run(0, 16'hA000, 11'h001, 1, `OFD_EXC_CSO, 0);
    bus(1, `OFD_REG_OPER, 32'h0000_FFFF);
    run(0, 16'h8002, 0, 1, `OFD_EXC_GP, 0);
    run(0, 16'h8000, 0, 0, 0, 0);
    bus(1, `OFD_REG_OPER, 0);
    run(3'h7, 16'h0100, 0, 1, `OFD_EXC_GP, 0);
    run(3'h7, 16'h0200, 0, 1, `OFD_EXC_GP, 0);
    run(1, 16'h0400, 11'h008, 1, `OFD_EXC_NP, 0);
    run(1, 16'h0C00, 11'h008, 1, `OFD_EXC_SS, 0);
    run(3'h3, 16'h0400, 0, 1, `OFD_EXC_GP, 0);
    run(1, 16'h8000, 11'h001, 1, `OFD_EXC_GP, 0);
    run(1, 16'h8000, 11'h002, 1, `OFD_EXC_GP, 0);
    run(1, 16'h8000, 11'h004, 1, `OFD_EXC_SS, 0);
    run(1, 16'h0080, 11'h100, 1, `OFD_EXC_GP, 0);
    run(1, 16'h0080, 11'h200, 1, `OFD_EXC_GP, 0);
    run(1, 16'hA000, 11'h001, 1, `OFD_EXC_GP, 0);
    run(1, 16'hA000, 11'h004, 1, `OFD_EXC_SS, 0);
    run(1, 16'hA000, 11'h400, 1, `OFD_EXC_CSO, 0);
    run(1, 16'h8010, 11'h001, 1, `OFD_EXC_GP, 0);
    run(1, 16'h0010, 0, 0, 0, 1);
    run(1, 16'h0040, 0, 0, 0, 1);
    run(1, 16'h0030, 0, 0, 0, 1);
    @(negedge hclk);
    compare(0, bus_lock);
    @(negedge hclk);
    compare(1, bus_lock);
    run(3'h7, 16'h1000, 0, 0, 0, 0);
    bus(0, `OFD_REG_STAT, 0);
    compare(2'h1, rd[11:10]);
    run(3'h7, 16'h1000, 11'h0C0, 0, 0, 0);
    bus(0, `OFD_REG_STAT, 0);
    compare(2'h2, rd[11:10]);
    run(1, 16'h4003, 0, 0, 0, 0);
    compare(1, extra_clock);
    bus(0, `OFD_REG_STAT, 0);
    compare(2'h3, rd[9:8]);
    run(1, 16'h0000, 0, 0, 0, 0);
    compare(0, extra_clock);
    bus(0, `OFD_REG_STAT, 0);
    compare(2'h0, rd[9:8]);
    bus(1, `OFD_REG_IMM, 32'h0000_1280);
    bus(0, `OFD_REG_IMM, 0);
    compare(32'h0000_0080, rd);
    bus(1, `OFD_REG_INSN, 32'h0000_0006);
    bus(0, `OFD_REG_IMM, 0);
    compare(32'h0000_FF80, rd);
    bus(1, `OFD_REG_INSN, 32'h0000_0002);
    bus(0, `OFD_REG_IMM, 0);
    compare(32'h0000_1280, rd);
    bus(1, `OFD_REG_CTRL, 0);
    bus(1, `OFD_REG_FLAGS, 32'h0000_7200);
    bus(0, `OFD_REG_FLAGS, 0);
    compare(32'h0000_0200, rd);
    bus(1, `OFD_REG_CTRL, 32'h0000_0007);
    bus(1, `OFD_REG_FLAGS, 32'h0000_3000);
    bus(0, `OFD_REG_FLAGS, 0);
    compare(32'h0000_0200, rd);
    bus(1, `OFD_REG_CTRL, 32'h0000_0001);
    bus(1, `OFD_REG_FLAGS, 32'h0000_3000);
    bus(0, `OFD_REG_FLAGS, 0);
    compare(32'h0000_3000, rd);
    bus(0, 32'h0000_001C, 0);
    compare(0, rd);
    compare(n_exp, seen_cnt);
    compare(`OFD_EXC_GP, seen_num);
    print_verdict;
  end
endmodule
